// ===== design/dbp_port.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_port (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // port3 bit7 pin (force bypass)
    input  wire logic       port3_bit7_in,
    output logic            port3_bit7_out,
    output logic            port3_bit7_oe,
    // port3 bit6 pin (signal detect)
    input  wire logic       port3_bit6_in,
    output logic            port3_bit6_out,
    output logic            port3_bit6_oe,
    // default pin configuration from other control registers
    input  wire logic       gp7_out,
    input  wire logic       gp7_oe,
    input  wire logic       gp6_out,
    input  wire logic       gp6_oe,
    input  wire logic [1:0] bypass_select,
    // interrupt
    output logic            irq_n,
    output logic [7:0]      bypass_irq_source
);
    dbp_pkg::dbp_bus_req_t  req;
    dbp_pkg::dbp_pin_drv_t  drv7;
    dbp_pkg::dbp_state_t    state;
    dbp_pkg::dbp_state_t    next_state;
    logic                   bypass_ctrl_enable;
    logic                   sig_detect_irq_enable;
    logic                   force_bypass;
    logic                   signal_detect;
    logic                   sd_edge;
    logic                   sd_raw7;
    logic [1:0]             irq_status;
    logic [1:0]             irq_enable;
    logic                   irq_any;
    logic [1:0]             ev;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    dbp_sd_filter #(
        .LEN(dbp_pkg::DBP_FILT_LEN)
    ) u_filt (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (port3_bit6_in),
        .level     (signal_detect),
        .edge_pulse(sd_edge)
    );

    // force_bypass readback of the synchronised and filtered pin 7 level while disabled
    dbp_sd_filter #(
        .LEN(dbp_pkg::DBP_FILT_LEN)
    ) u_filt7 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (port3_bit7_in),
        .level     (sd_raw7),
        .edge_pulse()
    );

    // control register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bypass_ctrl_enable    <= dbp_pkg::DBP_RST_EN;
            sig_detect_irq_enable <= dbp_pkg::DBP_RST_SIG_DETECT_IRQ_ENABLE;
        end else if (req.wr && hit(req.addr, dbp_pkg::DBP_ADDR_CTRL)) begin
            bypass_ctrl_enable    <= req.wdata[dbp_pkg::DBP_BIT_EN];
            sig_detect_irq_enable <= req.wdata[dbp_pkg::DBP_BIT_SIG_DETECT_IRQ_ENABLE];
        end
    end

    // force bypass bit, auto clear on loss wins over write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            force_bypass <= dbp_pkg::DBP_RST_FB;
        end else if (bypass_ctrl_enable && !signal_detect) begin
            force_bypass <= 1'b0;
        end else if (req.wr && hit(req.addr, dbp_pkg::DBP_ADDR_CTRL)) begin
            force_bypass <= req.wdata[dbp_pkg::DBP_BIT_FB];
        end
    end

    // output state
    always_comb begin
        next_state = dbp_pkg::DBP_ST_OFF;
        case (1'b1)
            !bypass_ctrl_enable: next_state = dbp_pkg::DBP_ST_OFF;
            force_bypass:        next_state = dbp_pkg::DBP_ST_NORMAL;
            default:             next_state = dbp_pkg::DBP_ST_BYPASS;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= dbp_pkg::DBP_ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // pin 7: bypass select keeps control, otherwise totem-pole drive in normal and bypass states, gp7 pass-through when off
    always_comb begin
        drv7 = '{o: gp7_out, oe: gp7_oe};
        if (bypass_select == 2'h0) begin
            case (state)
                dbp_pkg::DBP_ST_OFF:    drv7 = '{o: gp7_out, oe: gp7_oe};
                dbp_pkg::DBP_ST_NORMAL: drv7 = '{o: 1'b1, oe: 1'b1};
                dbp_pkg::DBP_ST_BYPASS: drv7 = '{o: 1'b0, oe: 1'b1};
                default:                drv7 = '{o: gp7_out, oe: gp7_oe};
            endcase
        end
    end

    assign port3_bit7_out = drv7.o;
    assign port3_bit7_oe  = drv7.oe;
    // pin 6 is an input while enabled
    assign port3_bit6_out = bypass_ctrl_enable ? 1'b0 : gp6_out;
    assign port3_bit6_oe  = bypass_ctrl_enable ? 1'b0 : gp6_oe;

    // interrupt events
    assign ev[dbp_pkg::DBP_IRQ_SD_EDGE] = bypass_ctrl_enable && sig_detect_irq_enable && sd_edge;
    assign ev[dbp_pkg::DBP_IRQ_SD_LOSS] = bypass_ctrl_enable && sd_edge && !signal_detect;

    dbp_irq #(
        .W(dbp_pkg::DBP_IRQ_W)
    ) u_irq (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .event_set(ev),
        .clr      (req.wdata[1:0]),
        .clr_wr   (req.wr && hit(req.addr, dbp_pkg::DBP_ADDR_IRQ_CLR)),
        .en_wdata (req.wdata[1:0]),
        .en_wr    (req.wr && hit(req.addr, dbp_pkg::DBP_ADDR_IRQ_EN)),
        .status   (irq_status),
        .enable   (irq_enable),
        .irq      (irq_any)
    );

    assign irq_n = ~(irq_any | (irq_status[dbp_pkg::DBP_IRQ_SD_EDGE]));

    // source register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bypass_irq_source <= dbp_pkg::DBP_RST_SRC;
        end else if (ev[dbp_pkg::DBP_IRQ_SD_EDGE]) begin
            bypass_irq_source <= dbp_pkg::DBP_ADDR_CTRL;
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                dbp_pkg::DBP_ADDR_CTRL: begin
                    rdata <= {bypass_ctrl_enable, sig_detect_irq_enable, 4'h0,
                              bypass_ctrl_enable ? force_bypass : sd_raw7,
                              signal_detect};
                end
                dbp_pkg::DBP_ADDR_IRQ_STAT: rdata <= {6'h00, irq_status};
                dbp_pkg::DBP_ADDR_IRQ_EN:   rdata <= {6'h00, irq_enable};
                dbp_pkg::DBP_ADDR_SRC:      rdata <= bypass_irq_source;
                default:                    rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // assertions
    AST_LOSS_CLEARS_FB: assert property (@(posedge ref_clk) disable iff (rst)
        (bypass_ctrl_enable && !signal_detect) |=> !force_bypass)
        else $error("force bypass not cleared on signal loss");
    AST_LOSS_LATENCY: assert property (@(posedge ref_clk) disable iff (rst)
        (bypass_ctrl_enable && $fell(signal_detect) && bypass_select == 2'h0 && !$changed(bypass_ctrl_enable))
        |-> ##[1:3] (port3_bit7_out == 1'b0))
        else $error("force bypass output late after loss");
    AST_NORMAL_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
        (state == dbp_pkg::DBP_ST_NORMAL && bypass_select == 2'h0) |-> (port3_bit7_out && port3_bit7_oe))
        else $error("normal mode output not high");
    AST_BYPASS_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        (state == dbp_pkg::DBP_ST_BYPASS && bypass_select == 2'h0) |-> (!port3_bit7_out && port3_bit7_oe))
        else $error("bypass mode output not low");
    AST_EDGE_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
        (bypass_ctrl_enable && sig_detect_irq_enable && sd_edge) |=> !irq_n)
        else $error("interrupt not asserted on transition");
    AST_NO_IRQ_DISABLED: assert property (@(posedge ref_clk) disable iff (rst)
        (!sig_detect_irq_enable && sd_edge) |=> !$rose(irq_status[dbp_pkg::DBP_IRQ_SD_EDGE]))
        else $error("interrupt raised while disabled");
    AST_SOURCE_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(irq_status[dbp_pkg::DBP_IRQ_SD_EDGE]) |-> (bypass_irq_source == dbp_pkg::DBP_ADDR_CTRL))
        else $error("source register not loaded");
    AST_PIN6_INPUT: assert property (@(posedge ref_clk) disable iff (rst)
        bypass_ctrl_enable |-> !port3_bit6_oe)
        else $error("signal detect pin driven while enabled");
    AST_DISABLED_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        (state == dbp_pkg::DBP_ST_OFF) |-> (port3_bit7_oe == gp7_oe && port3_bit7_out == gp7_out))
        else $error("pin 7 not passed through while disabled");
    AST_SD_READ: assert property (@(posedge ref_clk) disable iff (rst)
        (rd && addr == dbp_pkg::DBP_ADDR_CTRL) |=> (rdata[0] == $past(signal_detect)))
        else $error("signal detect readback wrong");

    COV_LOSS: cover property (@(posedge ref_clk) disable iff (rst)
        bypass_ctrl_enable && $fell(signal_detect));
    COV_IRQ: cover property (@(posedge ref_clk) disable iff (rst) $fell(irq_n));
    COV_NORMAL: cover property (@(posedge ref_clk) disable iff (rst) state == dbp_pkg::DBP_ST_NORMAL);
endmodule : dbp_port
`default_nettype wire

// ===== design/dbp_pkg.sv
package dbp_pkg;
    localparam logic [7:0] DBP_ADDR_CTRL     = 8'h23;
    localparam logic [7:0] DBP_ADDR_IRQ_STAT = 8'h30;
    localparam logic [7:0] DBP_ADDR_IRQ_CLR  = 8'h31;
    localparam logic [7:0] DBP_ADDR_IRQ_EN   = 8'h32;
    localparam logic [7:0] DBP_ADDR_SRC      = 8'h33;
    localparam int DBP_BIT_EN     = 7;
    localparam int DBP_BIT_SIG_DETECT_IRQ_ENABLE  = 6;
    localparam int DBP_BIT_FB     = 1;
    localparam int DBP_BIT_SD     = 0;
    localparam int DBP_BIT_BSEL_HI = 6;
    localparam int DBP_BIT_BSEL_LO = 5;
    localparam logic DBP_RST_EN    = 1'b0;
    localparam logic DBP_RST_SIG_DETECT_IRQ_ENABLE = 1'b0;
    localparam logic DBP_RST_FB    = 1'b1;
    localparam logic [7:0] DBP_RST_SRC = 8'h00;
    localparam int DBP_CLK_MHZ      = 250;
    localparam int DBP_FB_LAT_NS    = 400;
    localparam int DBP_FB_LAT_CYC   = (DBP_FB_LAT_NS * DBP_CLK_MHZ) / 1000;
    localparam int DBP_FILT_LEN     = 4;
    // interrupt status bit positions
    localparam int DBP_IRQ_SD_EDGE  = 0;
    localparam int DBP_IRQ_SD_LOSS  = 1;
    localparam int DBP_IRQ_W        = 2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dbp_bus_req_t;

    typedef struct packed {
        logic o;
        logic oe;
    } dbp_pin_drv_t;

    typedef enum logic [2:0] {
        DBP_ST_OFF    = 3'b001,
        DBP_ST_NORMAL = 3'b010,
        DBP_ST_BYPASS = 3'b100
    } dbp_state_t;
endpackage : dbp_pkg

// ===== design/dbp_sd_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_sd_filter #(
    parameter int LEN = dbp_pkg::DBP_FILT_LEN
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // pin and filtered output
    input  wire logic pin_in,
    output logic      level,
    output logic      edge_pulse
);
    logic       sync1;
    logic       sync2;
    logic [LEN-1:0] hist;

    // two-stage synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
        end
    end

    // history and majority-free filter: level changes only when all samples agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hist <= '1;
        end else begin
            hist <= {hist[LEN-2:0], sync2};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level      <= 1'b1;
            edge_pulse <= 1'b0;
        end else begin
            edge_pulse <= 1'b0;
            if (&hist && !level) begin
                level      <= 1'b1;
                edge_pulse <= 1'b1;
            end else if (~|hist && level) begin
                level      <= 1'b0;
                edge_pulse <= 1'b1;
            end
        end
    end
endmodule : dbp_sd_filter
`default_nettype wire

// ===== design/dbp_irq.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_irq #(
    parameter int W = dbp_pkg::DBP_IRQ_W
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // events and software access
    input  wire logic [W-1:0] event_set,
    input  wire logic [W-1:0] clr,
    input  wire logic         clr_wr,
    input  wire logic [W-1:0] en_wdata,
    input  wire logic         en_wr,
    output logic      [W-1:0] status,
    output logic      [W-1:0] enable,
    output logic              irq
);
    // sticky status, set wins over clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= (status & ~(clr_wr ? clr : '0)) | event_set;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enable <= '0;
        end else if (en_wr) begin
            enable <= en_wdata;
        end
    end

    assign irq = |(status & enable);
endmodule : dbp_irq
`default_nettype wire

// ===== verification/dbp_sd_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dbp_sd_unit #(
    parameter int DLY = 0
) (
    // clock and link state
    input  wire logic ref_clk,
    input  wire logic link_ok,
    // pins
    input  wire logic fb_pin,
    output var logic  sd_out,
    output var logic  bypassed
);
    logic [7:0] dl = 8'hFF;
    // signal detect follows the link after DLY+1 cycles
    always @(posedge ref_clk) begin
        dl <= {dl[6:0], link_ok};
    end
    assign sd_out = dl[DLY];
    // low force-bypass level puts the loop in bypass
    assign bypassed = ~fb_pin;
endmodule : dbp_sd_unit
`default_nettype wire

// ===== verification/tb_drive_bypass_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_drive_bypass_control_port;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr, wdata, rdata, src;
    logic        wr, rd, p7_out, p7_oe, p6_out, p6_oe, irq_n;
    logic        gp7_out, gp7_oe, gp6_out, gp6_oe, link_ok;
    logic [1:0]  bsel;
    logic        sd_out, bypassed, p7_lvl, p6_lvl;
    logic [32:0] rows [7];
    logic [7:0]  wd, mk, ex;
    logic [3:0]  gp;
    logic [1:0]  bs;
    logic [2:0]  pn;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          i, n;

    // pin7 has a pull-up; pin6 is shared by the unit and the port
    assign p7_lvl = p7_oe ? p7_out : 1'b1;
    assign p6_lvl = p6_oe ? p6_out : sd_out;

    dbp_port DUT (
        .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port3_bit7_in(p7_lvl), .port3_bit7_out(p7_out), .port3_bit7_oe(p7_oe),
        .port3_bit6_in(p6_lvl), .port3_bit6_out(p6_out), .port3_bit6_oe(p6_oe),
        .gp7_out(gp7_out), .gp7_oe(gp7_oe), .gp6_out(gp6_out), .gp6_oe(gp6_oe),
        .bypass_select(bsel), .irq_n(irq_n), .bypass_irq_source(src)
    );

    dbp_sd_unit #(.DLY(2)) unit (
        .ref_clk(ref_clk), .link_ok(link_ok), .fb_pin(p7_lvl), .sd_out(sd_out), .bypassed(bypassed)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata & m);
    endtask : rchk

    initial begin
        // wdata, gp pins, bsel, pins expected {7out,7oe,6oe}, read mask, read value
        rows[0] = {8'h00, 4'h7, 2'h0, 3'h3, 8'hFC, 8'h00};
        rows[1] = {8'h02, 4'hB, 2'h0, 3'h5, 8'hFC, 8'h00};
        rows[2] = {8'h82, 4'h3, 2'h0, 3'h6, 8'hFF, 8'h83};
        rows[3] = {8'h80, 4'h3, 2'h0, 3'h2, 8'hFF, 8'h81};
        rows[4] = {8'hBE, 4'h0, 2'h0, 3'h6, 8'hFF, 8'h83};
        rows[5] = {8'h82, 4'h4, 2'h1, 3'h2, 8'hFF, 8'h83};
        rows[6] = {8'h82, 4'h4, 2'h2, 3'h2, 8'hFF, 8'h83};
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        {gp7_out, gp7_oe, gp6_out, gp6_oe} = 4'h7;
        bsel = 2'h0;
        link_ok = 1'b1;
        #7;
        chk("irq_n rst", 8'h01, {7'h00, irq_n});
        chk("source rst", 8'h00, src);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(dbp_pkg::DBP_ADDR_CTRL, 8'hC0, 8'h00);
        rchk(8'h55, 8'hFF, 8'h00);
        for (i = 0; i < 7; i++) begin
            {wd, gp, bs, pn, mk, ex} = rows[i];
            @(posedge ref_clk);
            {gp7_out, gp7_oe, gp6_out, gp6_oe} <= gp;
            bsel <= bs;
            wr_reg(dbp_pkg::DBP_ADDR_CTRL, wd);
            tick(1);
            chk("pins", {5'h00, pn}, {5'h00, p7_out, p7_oe, p6_oe});
            chk("pin6 out", {7'h00, (wd[dbp_pkg::DBP_BIT_EN] ? 1'b0 : gp[1])}, {7'h00, p6_out});
            rchk(dbp_pkg::DBP_ADDR_CTRL, mk, ex);
        end
        @(posedge ref_clk);
        bsel <= 2'h0;
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_EN, 8'h00);
        wr_reg(dbp_pkg::DBP_ADDR_CTRL, 8'hC2);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_CLR, 8'h03);
        link_ok <= 1'b0;
        wait (sd_out === 1'b0);
        for (n = 0; n < dbp_pkg::DBP_FB_LAT_CYC && p7_out !== 1'b0; n++) @(posedge ref_clk);
        #1;
        chk("fb pin", 8'h00, {7'h00, p7_out});
        chk("bypass", 8'h01, {7'h00, bypassed});
        chk("irq_n fall", 8'h00, {7'h00, irq_n});
        chk("source", 8'h23, src);
        rchk(dbp_pkg::DBP_ADDR_SRC, 8'hFF, dbp_pkg::DBP_ADDR_CTRL);
        rchk(dbp_pkg::DBP_ADDR_CTRL, 8'hFF, 8'hC0);
        rchk(dbp_pkg::DBP_ADDR_IRQ_STAT, 8'h03, 8'h03);
        wr_reg(dbp_pkg::DBP_ADDR_CTRL, 8'hC2);
        rchk(dbp_pkg::DBP_ADDR_CTRL, 8'hFF, 8'hC0);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_CLR, 8'h03);
        tick(1);
        chk("irq_n clr", 8'h01, {7'h00, irq_n});
        link_ok <= 1'b1;
        tick(20);
        chk("irq_n rise", 8'h00, {7'h00, irq_n});
        rchk(dbp_pkg::DBP_ADDR_IRQ_STAT, 8'h01, 8'h01);
        wr_reg(dbp_pkg::DBP_ADDR_CTRL, 8'h82);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_CLR, 8'h03);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_EN, 8'h02);
        link_ok <= 1'b0;
        tick(20);
        rchk(dbp_pkg::DBP_ADDR_IRQ_STAT, 8'h01, 8'h00);
        chk("irq_n loss", 8'h00, {7'h00, irq_n});
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_EN, 8'h00);
        tick(1);
        chk("irq_n mask", 8'h01, {7'h00, irq_n});
        rchk(dbp_pkg::DBP_ADDR_IRQ_EN, 8'h03, 8'h00);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_CLR, 8'h03);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_EN, 8'h02);
        tick(1);
        chk("irq_n unmask", 8'h01, {7'h00, irq_n});
        link_ok <= 1'b1;
        tick(20);
        wr_reg(dbp_pkg::DBP_ADDR_CTRL, 8'hC2);
        wr_reg(dbp_pkg::DBP_ADDR_IRQ_CLR, 8'h03);
        // two-cycle dropout must be filtered away
        @(posedge ref_clk);
        link_ok <= 1'b0;
        repeat (2) @(posedge ref_clk);
        link_ok <= 1'b1;
        tick(20);
        chk("irq_n glitch", 8'h01, {7'h00, irq_n});
        rchk(dbp_pkg::DBP_ADDR_CTRL, 8'hFF, 8'hC3);
        @(posedge ref_clk);
        rst <= 1'b1;
        tick(2);
        chk("source rst2", 8'h00, src);
        chk("irq_n rst2", 8'h01, {7'h00, irq_n});
        @(posedge ref_clk);
        rst <= 1'b0;
        rchk(dbp_pkg::DBP_ADDR_CTRL, 8'hC0, 8'h00);
        end_of_test();
    end
endmodule : tb_drive_bypass_control_port
`default_nettype wire
